// File: shared/rtcbd_pkg.sv
// Constants and types shared by the real-time clock with backup storage.
// Overview of operation
// RULE1: Sixty-four sixteen-bit backup words, 128 bytes, readable and writable.
// RULE2: Backup words survive system reset, power reset and standby wake.
// RULE3: Two event outputs: alarm match and periodic time-base tick.
// RULE4: Clock source selects crystal, low-power RC, or fast clock over 128.
// RULE5: Clock divided by 64 drives the calibration pin when enabled.
// RULE6: A 32-bit loadable counter; alarm fires when it matches compare.
// RULE7: A 20-bit prescaler makes the tick; default gives one second.
// RULE8: Counting continues regardless of Stop or Standby mode inputs.
// RULE9: An alarm during Standby raises the standby exit request.
// RULE10: The alarm drives its external event line to wake from Stop.
// RULE11: Prescaler counts down from reload, ticks on underflow; reload 32767.
package rtcbd_pkg;
    localparam int PRE_W = 20;
    localparam logic [PRE_W-1:0] PRE_RELOAD_RST = 20'h07fff;
    localparam int CNT_W = 32;
    localparam int BKP_DEPTH = 64;
    localparam int BKP_W = 16;
    localparam int BKP_IDX_W = 6;
    localparam int FAST_DIV_W = 7;
    localparam logic [FAST_DIV_W-1:0] FAST_DIV_LAST = 7'h7f;
    localparam int CAL_HALF_W = 5;
    localparam logic [CAL_HALF_W-1:0] CAL_HALF_LAST = 5'h1f;
    localparam int SYNC_N = 3;
    localparam int SYNC_XTAL = 0;
    localparam int SYNC_LPRC = 1;
    localparam int SYNC_FAST = 2;
    localparam int SLOW_XTAL_HZ = 32768;

    // Encoding of the two-bit clock source select input.
    typedef enum logic [1:0] {
        RTCBD_SRC_XTAL,
        RTCBD_SRC_LPRC,
        RTCBD_SRC_FAST
    } rtcbd_src_t;
endpackage : rtcbd_pkg

// File: src/rtcbd_top.sv
// Real-time clock core: prescaler, counter, alarm, calibration and backup.
`timescale 1ns/10ps
module rtcbd_top (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [1:0] clk_sel,
    input wire logic slow_xtal_in,
    input wire logic lp_rc_in,
    input wire logic fast_external_clock_in,
    input wire logic stop_mode,
    input wire logic standby_mode,
    input wire logic prescale_load,
    input wire logic [rtcbd_pkg::PRE_W-1:0] prescale_reload,
    input wire logic counter_load,
    input wire logic [rtcbd_pkg::CNT_W-1:0] counter_value,
    input wire logic alarm_load,
    input wire logic [rtcbd_pkg::CNT_W-1:0] alarm_value,
    input wire logic calib_enable,
    input wire logic bkp_wr,
    input wire logic [rtcbd_pkg::BKP_IDX_W-1:0] bkp_index,
    input wire logic [rtcbd_pkg::BKP_W-1:0] bkp_wdata,
    output logic [rtcbd_pkg::BKP_W-1:0] bkp_rdata,
    output logic [rtcbd_pkg::CNT_W-1:0] count,
    output logic tick_event,
    output logic alarm_event,
    output logic external_event_lines_alarm,
    output logic standby_exit,
    output logic calibration_output_pin_out,
    output logic calibration_output_pin_oe_n
);
    localparam int PW = rtcbd_pkg::PRE_W;
    localparam int CW = rtcbd_pkg::CNT_W;
    localparam int SN = rtcbd_pkg::SYNC_N;

    logic [SN-1:0] raw_in;
    logic [SN-1:0] s0_q, s1_q, s2_q;
    logic [SN-1:0] rise;
    logic [rtcbd_pkg::FAST_DIV_W-1:0] fdiv_q, fdiv_d;
    logic fast_en, slow_en;
    logic [PW-1:0] pre_q, pre_d, reload_q, reload_d;
    logic [CW-1:0] cnt_q, cnt_d, cmp_q, cmp_d;
    logic tick_q, tick_d, alarm_q, alarm_d, wake_q, wake_d;
    logic [rtcbd_pkg::CAL_HALF_W-1:0] cal_cnt_q, cal_cnt_d;
    logic cal_q, cal_d, cal_oe_n_q, cal_oe_n_d;
    logic [rtcbd_pkg::BKP_W-1:0] bkp_q [rtcbd_pkg::BKP_DEPTH];
    logic [rtcbd_pkg::BKP_W-1:0] bkp_d [rtcbd_pkg::BKP_DEPTH];
    logic [rtcbd_pkg::BKP_W-1:0] rdata_q, rdata_d;

    assign raw_in[rtcbd_pkg::SYNC_XTAL] = slow_xtal_in;
    assign raw_in[rtcbd_pkg::SYNC_LPRC] = lp_rc_in;
    assign raw_in[rtcbd_pkg::SYNC_FAST] = fast_external_clock_in;

    // The clock pins are sampled, never used as clocks, so the core keeps a
    // single domain; the fast source must stay well below half of clk.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s0_q <= '0;
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s0_q <= raw_in;
            s1_q <= s0_q;
            s2_q <= s1_q;
        end
    end

    // Rising edges are taken from the second and third stages. A pin that is high
    // as reset ends shows one early edge; the sources run free, so at worst
    // the first period after reset ends one source edge early.
    assign rise = s1_q & ~s2_q;

    // Fast clock divided by 128 and the source select.
    always_comb begin
        fdiv_d = fdiv_q;
        fast_en = 1'b0;
        if (rise[rtcbd_pkg::SYNC_FAST]) begin
            fdiv_d = fdiv_q + 1'b1;
            fast_en = (fdiv_q == rtcbd_pkg::FAST_DIV_LAST); // RULE4
        end
        case (rtcbd_pkg::rtcbd_src_t'(clk_sel))
            rtcbd_pkg::RTCBD_SRC_XTAL: slow_en = rise[rtcbd_pkg::SYNC_XTAL];
            rtcbd_pkg::RTCBD_SRC_LPRC: slow_en = rise[rtcbd_pkg::SYNC_LPRC];
            rtcbd_pkg::RTCBD_SRC_FAST: slow_en = fast_en; // RULE4
            default: slow_en = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fdiv_q <= '0;
        end else begin
            fdiv_q <= fdiv_d;
        end
    end

    // Prescaler, counter and alarm. Stop and Standby inputs deliberately do not
    // gate prescaler or counter, so the time base keeps running in both modes.
    always_comb begin
        reload_d = reload_q;
        pre_d = pre_q;
        cnt_d = cnt_q;
        cmp_d = cmp_q;
        tick_d = 1'b0;
        alarm_d = 1'b0;
        if (alarm_load) begin
            cmp_d = alarm_value; // RULE6
        end
        if (prescale_load) begin
            reload_d = prescale_reload;
            pre_d = prescale_reload;
        end else if (slow_en) begin // RULE8
            if (pre_q == '0) begin
                pre_d = reload_q; // RULE11
                tick_d = 1'b1; // RULE7
            end else begin
                pre_d = pre_q - 1'b1; // RULE11
            end
        end
        // A software load wins over a tick in the same cycle.
        if (counter_load) begin
            cnt_d = counter_value;
        end else if (tick_d) begin
            cnt_d = cnt_q + 1'b1; // RULE6
            alarm_d = (cnt_d == cmp_d); // RULE6
        end
        wake_d = alarm_d && standby_mode; // RULE9
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reload_q <= rtcbd_pkg::PRE_RELOAD_RST; // RULE11
            pre_q <= rtcbd_pkg::PRE_RELOAD_RST;
            cnt_q <= '0;
            cmp_q <= '1;
            tick_q <= 1'b0;
            alarm_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            reload_q <= reload_d;
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            cmp_q <= cmp_d;
            tick_q <= tick_d;
            alarm_q <= alarm_d;
            wake_q <= wake_d;
        end
    end

    assign count = cnt_q;
    assign tick_event = tick_q; // RULE3
    assign alarm_event = alarm_q; // RULE3
    assign external_event_lines_alarm = alarm_q; // RULE10
    assign standby_exit = wake_q; // RULE9

    // Calibration output: toggling every 32 source edges gives clock over 64.
    always_comb begin
        cal_cnt_d = cal_cnt_q;
        cal_d = cal_q;
        cal_oe_n_d = ~calib_enable;
        if (slow_en) begin
            cal_cnt_d = cal_cnt_q + 1'b1;
            if (cal_cnt_q == rtcbd_pkg::CAL_HALF_LAST) begin
                cal_d = ~cal_q; // RULE5
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cal_cnt_q <= '0;
            cal_q <= 1'b0;
            cal_oe_n_q <= 1'b1;
        end else begin
            cal_cnt_q <= cal_cnt_d;
            cal_q <= cal_d;
            cal_oe_n_q <= cal_oe_n_d;
        end
    end

    assign calibration_output_pin_out = cal_q; // RULE5
    assign calibration_output_pin_oe_n = cal_oe_n_q;

    // Backup words: one write port, registered read of the indexed word.
    always_comb begin
        for (int i = 0; i < rtcbd_pkg::BKP_DEPTH; i++) begin
            bkp_d[i] = bkp_q[i];
        end
        if (bkp_wr) begin
            bkp_d[bkp_index] = bkp_wdata; // RULE1
        end
        rdata_d = bkp_q[bkp_index]; // RULE1
    end

    // No reset on purpose: the contents must outlive every reset.
    always_ff @(posedge clk) begin
        for (int i = 0; i < rtcbd_pkg::BKP_DEPTH; i++) begin
            bkp_q[i] <= bkp_d[i]; // RULE2
        end
        rdata_q <= rdata_d;
    end

    assign bkp_rdata = rdata_q;

    // Properties run on the system clock and sleep while reset is held, so
    // the values seen just after release come from the reset branch.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence underflow_s;
        slow_en && !prescale_load && (pre_q == '0);
    endsequence

    sequence bkp_write_s;
        bkp_wr ##1 (!bkp_wr && bkp_index == $past(bkp_index));
    endsequence

    tick_on_underflow_a: assert property ( // RULE7
        underflow_s |=> tick_q && pre_q == $past(reload_q))
        else $error("Tick or reload missing after prescaler underflow.");

    tick_only_underflow_a: assert property ( // RULE11
        tick_q |-> $past(pre_q) == '0 && $past(slow_en))
        else $error("Tick without prescaler underflow.");

    count_step_a: assert property ( // RULE6
        tick_q && !$past(counter_load) |-> cnt_q == $past(cnt_q) + 1'b1)
        else $error("Counter did not advance by one on tick.");

    alarm_match_a: assert property ( // RULE6
        alarm_q |-> tick_q && cnt_q == cmp_q)
        else $error("Alarm without counter match.");

    alarm_hit_a: assert property ( // RULE3
        slow_en && pre_q == '0 && !prescale_load && !counter_load &&
        !alarm_load && cnt_q + 1'b1 == cmp_q |=> alarm_q)
        else $error("Counter matched compare but no alarm.");

    event_line_a: assert property ( // RULE10
        external_event_lines_alarm == alarm_q)
        else $error("Event line differs from alarm.");

    standby_wake_a: assert property ( // RULE9
        alarm_d && standby_mode |=> standby_exit ##1 !standby_exit)
        else $error("Standby exit not pulsed on alarm.");

    mode_runs_a: assert property ( // RULE8
        (stop_mode || standby_mode) && slow_en && !prescale_load &&
        pre_q != '0 |=> pre_q == $past(pre_q) - 1'b1)
        else $error("Prescaler stalled in low-power mode.");

    cal_toggle_a: assert property ( // RULE5
        slow_en && cal_cnt_q == rtcbd_pkg::CAL_HALF_LAST |=>
        cal_q != $past(cal_q))
        else $error("Calibration output did not toggle.");

    fast_div_a: assert property ( // RULE4
        fast_en |-> fdiv_q == rtcbd_pkg::FAST_DIV_LAST &&
        rise[rtcbd_pkg::SYNC_FAST])
        else $error("Fast divider enable at wrong count.");

    bkp_readback_a: assert property ( // RULE1
        bkp_write_s |=> bkp_rdata == $past(bkp_wdata, 2))
        else $error("Backup word read back wrong.");

    // Load, event and pin-drive checks; every load input is a one-cycle pulse.
    reload_hold_a: assert property ( // RULE11
        !prescale_load |=> $stable(reload_q))
        else $error("Reload value changed without a load.");

    prescale_load_a: assert property ( // RULE11
        prescale_load |=> pre_q == $past(prescale_reload) &&
        reload_q == $past(prescale_reload) && !tick_q)
        else $error("Prescaler load not applied.");

    count_hold_a: assert property ( // RULE6
        !counter_load && !(slow_en && !prescale_load && pre_q == '0)
        |=> $stable(cnt_q))
        else $error("Counter moved without tick or load.");

    counter_load_a: assert property ( // RULE6
        counter_load |=> count == $past(counter_value) && !alarm_event)
        else $error("Counter load not applied or raised an alarm.");

    alarm_load_a: assert property ( // RULE6
        alarm_load |=> cmp_q == $past(alarm_value))
        else $error("Compare value not loaded.");

    tick_pulse_a: assert property ( // RULE3
        tick_event |=> !tick_event)
        else $error("Periodic event longer than one cycle.");

    standby_quiet_a: assert property ( // RULE9
        !standby_mode |=> !standby_exit)
        else $error("Standby exit raised outside standby.");

    wake_cause_a: assert property ( // RULE9
        standby_exit |-> alarm_event && tick_event)
        else $error("Standby exit without an alarm.");

    cal_drive_a: assert property ( // RULE5
        calib_enable |=> !calibration_output_pin_oe_n)
        else $error("Calibration pin not driven when enabled.");

    cal_idle_a: assert property ( // RULE5
        !calib_enable |=> calibration_output_pin_oe_n)
        else $error("Calibration pin driven while disabled.");
endmodule : rtcbd_top

// File: test/rtcbd_src_model.sv
// Free-running models of the three clock sources seen by the block.
`timescale 1ns/10ps
module rtcbd_src_model #(
    parameter int XTAL_HALF_NS = 24,
    parameter int LPRC_HALF_NS = 40,
    parameter int FAST_HALF_NS = 20
) (
    output logic xtal,
    output logic lprc,
    output logic fast
);
    // The oscillators run free; a 3 ns offset keeps their edges off clk.
    initial begin
        xtal = 1'b0;
        lprc = 1'b0;
        fast = 1'b0;
        #3;
        fork
            forever #(XTAL_HALF_NS) xtal = ~xtal;
            forever #(LPRC_HALF_NS) lprc = ~lprc;
            forever #(FAST_HALF_NS) fast = ~fast;
        join
    end
endmodule : rtcbd_src_model

// File: test/rtcbd_top_tb.sv
// Self-checking bench for the real-time clock with backup storage.
`timescale 1ns/10ps
module rtcbd_top_tb;
    logic clk, nrst, prescale_load, counter_load, alarm_load, calib_enable;
    logic stop_mode, standby_mode, bkp_wr, tick_event, alarm_event, ext_alarm;
    logic standby_exit, cal_out, cal_oe_n, xtal, lprc, fast;
    logic [1:0] clk_sel;
    logic [19:0] prescale_reload;
    logic [31:0] counter_value, alarm_value, count;
    logic [5:0] bkp_index;
    logic [15:0] bkp_wdata, bkp_rdata;
    int errors = 0;
    int check_count = 0;

    rtcbd_src_model u_src (.xtal(xtal), .lprc(lprc), .fast(fast));

    rtcbd_top u_dut (
        .clk(clk), .nrst(nrst), .clk_sel(clk_sel),
        .slow_xtal_in(xtal), .lp_rc_in(lprc), .fast_external_clock_in(fast),
        .stop_mode(stop_mode), .standby_mode(standby_mode),
        .prescale_load(prescale_load), .prescale_reload(prescale_reload),
        .counter_load(counter_load), .counter_value(counter_value),
        .alarm_load(alarm_load), .alarm_value(alarm_value),
        .calib_enable(calib_enable), .bkp_wr(bkp_wr), .bkp_index(bkp_index),
        .bkp_wdata(bkp_wdata), .bkp_rdata(bkp_rdata), .count(count),
        .tick_event(tick_event), .alarm_event(alarm_event),
        .external_event_lines_alarm(ext_alarm), .standby_exit(standby_exit),
        .calibration_output_pin_out(cal_out),
        .calibration_output_pin_oe_n(cal_oe_n)
    );

    // Free-running system clock.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic complete_run();
        if (errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    // Sync jitter allows two cycles either way on measured spans.
    task automatic chk_near(input int got, input int exp);
        check_count++;
        if (got < exp - 2 || got > exp + 2) begin
            errors++;
            $display("MISMATCH %0t took %0d want %0d", $time, got, exp);
        end
    endtask : chk_near

    task automatic wait_tick(output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (tick_event !== 1'b1 && n < 6000);
    endtask : wait_tick

    task automatic wait_toggle(output int n);
        logic v;
        v = cal_out;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (cal_out === v && n < 6000);
    endtask : wait_toggle

    // A reload of 3 keeps every tick period short.
    task automatic set_src(input logic [1:0] s);
        @(negedge clk);
        clk_sel = s;
        prescale_reload = 20'h00003;
        prescale_load = 1'b1;
        @(negedge clk);
        prescale_load = 1'b0;
    endtask : set_src

    // Reset values first, before any source edge clears the sync chain.
    task automatic test_reset_values();
        @(negedge clk);
        chk(count, 32'h0);
        chk({28'h0, tick_event, alarm_event, standby_exit, cal_out},
            32'h0);
        chk({30'h0, cal_oe_n, cal_out}, 32'h2);
        repeat (2000) @(negedge clk);
        chk(count, 32'h0);
    endtask : test_reset_values

    task automatic test_sources();
        int n;
        int per [3] = '{24, 40, 2560};
        logic [31:0] c;
        for (int s = 0; s < 3; s++) begin
            set_src(s[1:0]);
            wait_tick(n);
            c = count;
            wait_tick(n);
            chk_near(n, per[s]);
            chk(count, c + 32'h1);
        end
        set_src(2'h3);
        wait_tick(n);
        chk_near(n, 6000);
    endtask : test_sources

    // Loads near wrap so the match happens on the roll to zero.
    task automatic test_alarm();
        int n;
        for (int s = 0; s < 2; s++) begin
            set_src(2'h0);
            standby_mode = s[0];
            stop_mode = 1'b1;
            counter_value = 32'hfffffffe;
            alarm_value = 32'h0;
            counter_load = 1'b1;
            alarm_load = 1'b1;
            @(negedge clk);
            counter_load = 1'b0;
            alarm_load = 1'b0;
            wait_tick(n);
            chk(count, 32'hffffffff);
            chk({31'h0, alarm_event}, 32'h0);
            wait_tick(n);
            chk(count, 32'h0);
            chk({29'h0, alarm_event, ext_alarm, standby_exit},
                {29'h0, 2'b11, s[0]});
        end
        standby_mode = 1'b0;
        stop_mode = 1'b0;
    endtask : test_alarm

    task automatic test_cal();
        int n;
        set_src(2'h0);
        calib_enable = 1'b1;
        repeat (2) @(negedge clk);
        chk({31'h0, cal_oe_n}, 32'h0);
        wait_toggle(n);
        wait_toggle(n);
        chk_near(n, 192);
        calib_enable = 1'b0;
        repeat (2) @(negedge clk);
        chk({31'h0, cal_oe_n}, 32'h1);
    endtask : test_cal

    // Words must survive a reset taken while in standby.
    task automatic test_backup();
        for (int i = 0; i < 64; i += 21) begin
            @(negedge clk);
            bkp_wr = 1'b1;
            bkp_index = i[5:0];
            bkp_wdata = {i[7:0], ~i[7:0]};
        end
        @(negedge clk);
        bkp_wr = 1'b0;
        standby_mode = 1'b1;
        nrst = 1'b0;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        standby_mode = 1'b0;
        for (int i = 0; i < 64; i += 21) begin
            @(negedge clk);
            bkp_index = i[5:0];
            @(negedge clk);
            chk({16'h0, bkp_rdata}, {16'h0, i[7:0], ~i[7:0]});
        end
        // The old reload of 3 would tick within 24 cycles; reset restores it.
        repeat (40) @(negedge clk);
        chk(count, 32'h0);
        chk({31'h0, cal_oe_n}, 32'h1);
    endtask : test_backup

    // Watchdog sized well above the expected run of some 14000 cycles.
    initial begin
        #400000;
        errors++;
        complete_run();
    end

    // Main sequence.
    initial begin
        nrst = 1'b0;
        {prescale_load, counter_load, alarm_load, calib_enable} = 4'h0;
        {stop_mode, standby_mode, bkp_wr} = 3'h0;
        clk_sel = 2'h0;
        prescale_reload = 20'h0;
        counter_value = 32'h0;
        alarm_value = 32'h0;
        bkp_index = 6'h0;
        bkp_wdata = 16'h0;
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        test_reset_values();
        test_sources();
        test_alarm();
        test_cal();
        test_backup();
        complete_run();
    end
endmodule : rtcbd_top_tb
